// >>> core/hlbc_link_buffer_count_ctrl.sv
// Purpose: data-link buffer selection and byte/repeat count registers
// Assumes: AXI4-Lite slave, framer supplies message events
// Notes:   buffer memories, FCS and framing live outside
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/10ps

// Summary of operation
// - Written select bit, while tx is idle, chooses tx buffer zero or one for sending.
// - Read select bit returns next free tx buffer, zero or one.
// - While a buffer is busy, reads report the other free buffer.
// - Bit mode: after count repeats raise tx end interrupt and stop.
// - Bit mode: tx count zero repeats message without limit.
// - Message mode: tx count is length with header, without check octets.
// - Rx pointer names buffer holding newest received message.
// - Bit mode: rx count repetitions raise rx end interrupt.
// - Bit mode: rx count zero receives forever, no rx end interrupt.
// - Message mode: rx count reports size including header and check.
// - Shared mode bit: zero bit-oriented, one message-oriented.
module hlbc_link_buffer_count_ctrl (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  tx_msg_done,
	input  wire logic                  rx_msg_done,
	input  wire logic [6:0]            rx_msg_size,
	output logic                       tx_start,
	output logic                       tx_buffer_out,
	output logic [6:0]                 tx_length_out,
	output logic                       message_oriented_mode,
	output logic                       tx_busy,
	output logic                       irq
);
	typedef struct packed {
		logic                           aw_got;
		logic [7:0]                     aw_addr;
		logic                           w_got;
		logic [31:0]                    w_data;
		logic [3:0]                     w_strb;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           rvalid;
		logic [31:0]                    rdata;
		logic [1:0]                     rresp;
		logic                           tx_sel;
		logic                           tx_run_buf;
		logic [hlbc_pkg::CNT_W-1:0]     tx_cnt;
		logic                           tx_start;
		logic                           rx_ptr;
		logic [hlbc_pkg::CNT_W-1:0]     rx_cnt;
		logic [hlbc_pkg::CNT_W-1:0]     rx_seen;
		logic                           mode;
		logic [hlbc_pkg::IRQ_W-1:0]     stat;
		logic [hlbc_pkg::IRQ_W-1:0]     mask;
	} hlbc_state_type;

	hlbc_state_type s_q, s_d;
	hlbc_link_if    link ();

	// Next free buffer: while busy the running one is never offered
	function automatic logic free_buf(input logic sel, input logic busy,
		input logic run_buf);
		free_buf = busy ? ~run_buf : sel;
	endfunction

	function automatic logic [31:0] pack_bc(input logic b,
		input logic [hlbc_pkg::CNT_W-1:0] c);
		pack_bc = 32'h0000_0000;
		pack_bc[hlbc_pkg::SEL_BIT] = b;
		pack_bc[hlbc_pkg::CNT_W-1:0] = c;
	endfunction

	hlbc_tx_seq u_seq (
		.aclk    (aclk),
		.aresetn (aresetn),
		.link    (link)
	);

	assign link.start    = s_q.tx_start;
	assign link.count    = s_q.tx_cnt;
	assign link.bit_mode = ~s_q.mode;
	assign link.msg_done = tx_msg_done;

	logic                       do_wr;
	logic                       do_rd;
	logic [hlbc_pkg::IRQ_W-1:0] ev;

	always_comb begin
		s_d = s_q;
		s_d.tx_start = 1'b0;
		ev = '0;
		do_wr = 1'b0;
		do_rd = 1'b0;

		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Transmit end of transfer
		if (link.eot) begin
			ev[hlbc_pkg::IRQ_TX_BIT] = 1'b1;
		end

		// Receive side: pointer toggles to the buffer just filled
		if (rx_msg_done) begin
			s_d.rx_ptr = ~s_q.rx_ptr;
			if (s_q.mode) begin
				s_d.rx_cnt = rx_msg_size;
			end else if (s_q.rx_cnt != hlbc_pkg::CNT_RESET) begin
				// Zero target is skipped by the check above, so no event
				if (s_q.rx_seen + 7'h01 == s_q.rx_cnt) begin
					ev[hlbc_pkg::IRQ_RX_BIT] = 1'b1;
					s_d.rx_seen = hlbc_pkg::CNT_RESET;
				end else begin
					s_d.rx_seen = s_q.rx_seen + 7'h01;
				end
			end
		end

		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			do_wr = 1'b1;
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = hlbc_pkg::RESP_OKAY;
			case (s_q.aw_addr)
			hlbc_pkg::ADDR_TX_BC: begin
				if (s_q.w_strb[0]) begin
					// Software keeps off the busy buffer
					s_d.tx_sel = s_q.w_data[hlbc_pkg::SEL_BIT];
					s_d.tx_cnt = s_q.w_data[hlbc_pkg::CNT_W-1:0];
					if (!link.busy) begin
						s_d.tx_start = 1'b1;
						s_d.tx_run_buf = s_q.w_data[hlbc_pkg::SEL_BIT];
					end
				end
			end
			hlbc_pkg::ADDR_RX_BC: begin
				if (s_q.w_strb[0]) begin
					s_d.rx_ptr = s_q.w_data[hlbc_pkg::SEL_BIT];
					s_d.rx_cnt = s_q.w_data[hlbc_pkg::CNT_W-1:0];
					s_d.rx_seen = hlbc_pkg::CNT_RESET;
				end
			end
			hlbc_pkg::ADDR_CTRL: begin
				if (s_q.w_strb[0]) begin
					s_d.mode = s_q.w_data[hlbc_pkg::MODE_BIT];
				end
			end
			hlbc_pkg::ADDR_IRQ_STAT: begin
				if (s_q.w_strb[0]) begin
					s_d.stat = s_q.stat &
						~s_q.w_data[hlbc_pkg::IRQ_W-1:0];
				end
			end
			hlbc_pkg::ADDR_IRQ_MASK: begin
				if (s_q.w_strb[0]) begin
					s_d.mask = s_q.w_data[hlbc_pkg::IRQ_W-1:0];
				end
			end
			default: s_d.bresp = hlbc_pkg::RESP_SLVERR;
			endcase
		end
		// Set after clear so a same-cycle event survives
		s_d.stat = s_d.stat | ev;

		if (s_axi_arvalid && !s_q.rvalid) begin
			do_rd = 1'b1;
			s_d.rvalid = 1'b1;
			s_d.rresp = hlbc_pkg::RESP_OKAY;
			case (s_axi_araddr)
			hlbc_pkg::ADDR_TX_BC: s_d.rdata = pack_bc(
				free_buf(s_q.tx_sel, link.busy, s_q.tx_run_buf),
				s_q.tx_cnt);
			hlbc_pkg::ADDR_RX_BC:
				s_d.rdata = pack_bc(s_q.rx_ptr, s_q.rx_cnt);
			hlbc_pkg::ADDR_CTRL: begin
				s_d.rdata = 32'h0000_0000;
				s_d.rdata[hlbc_pkg::MODE_BIT] = s_q.mode;
			end
			hlbc_pkg::ADDR_IRQ_STAT:
				s_d.rdata = {30'h0000_0000, s_q.stat};
			hlbc_pkg::ADDR_IRQ_MASK:
				s_d.rdata = {30'h0000_0000, s_q.mask};
			default: begin
				s_d.rdata = 32'h0000_0000;
				s_d.rresp = hlbc_pkg::RESP_SLVERR;
			end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = ~s_q.aw_got;
	assign s_axi_wready  = ~s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = ~s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	assign tx_start              = s_q.tx_start;
	assign tx_buffer_out         = s_q.tx_run_buf;
	assign tx_length_out         = s_q.tx_cnt;
	assign message_oriented_mode = s_q.mode;
	assign tx_busy               = link.busy;
	assign irq                   = |(s_q.stat & s_q.mask);
endmodule

// >>> core/hlbc_pkg.sv
// Purpose: constants and types shared by the data-link buffer/count block
// Assumes: AXI4-Lite register bus, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package hlbc_pkg;
	localparam logic [7:0] ADDR_TX_BC    = 8'h00;
	localparam logic [7:0] ADDR_RX_BC    = 8'h04;
	localparam logic [7:0] ADDR_CTRL     = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

	localparam int CNT_W       = 7;
	localparam int SEL_BIT     = 7;
	localparam int MODE_BIT    = 0;
	localparam int IRQ_TX_BIT  = 0;
	localparam int IRQ_RX_BIT  = 1;
	localparam int IRQ_W       = 2;

	localparam logic [CNT_W-1:0] CNT_RESET   = 7'h00;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		HLBC_TX_IDLE = 2'b00,
		HLBC_TX_SEND = 2'b01,
		HLBC_TX_DONE = 2'b10
	} hlbc_tx_state_type;
endpackage

// >>> core/hlbc_link_if.sv
// Purpose: link-side event carrier between control core and tx sequencer
// Assumes: single clock domain
// Notes:   pulses are one cycle wide
`timescale 1ns/10ps
interface hlbc_link_if;
	logic                            start;
	logic [hlbc_pkg::CNT_W-1:0]      count;
	logic                            bit_mode;
	logic                            msg_done;
	logic                            busy;
	logic                            eot;
	modport core (output start, output count, output bit_mode,
		output msg_done, input busy, input eot);
	modport seq  (input start, input count, input bit_mode,
		input msg_done, output busy, output eot);
endinterface

// >>> core/hlbc_tx_seq.sv
// Purpose: counts transmitted messages or repetitions, flags end of transfer
// Assumes: msg_done pulses once per message sent by the framer
// Notes:   zero count in bit-oriented mode repeats forever
`timescale 1ns/10ps
module hlbc_tx_seq (
	input  wire logic aclk,
	input  wire logic aresetn,
	hlbc_link_if.seq  link
);
	typedef struct packed {
		hlbc_pkg::hlbc_tx_state_type   st;
		logic [hlbc_pkg::CNT_W-1:0]    left;
		logic                          bit_mode;
		logic                          eot;
	} hlbc_seq_state_type;

	hlbc_seq_state_type s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.eot = 1'b0;
		case (s_q.st)
		hlbc_pkg::HLBC_TX_IDLE: begin
			if (link.start) begin
				s_d.st = hlbc_pkg::HLBC_TX_SEND;
				s_d.left = link.count;
				s_d.bit_mode = link.bit_mode;
			end
		end
		hlbc_pkg::HLBC_TX_SEND: begin
			if (link.msg_done) begin
				// Message mode sends one frame; length is used by the framer
				if (!s_q.bit_mode) begin
					s_d.st = hlbc_pkg::HLBC_TX_DONE;
				end else if (s_q.left == hlbc_pkg::CNT_RESET) begin
					s_d.st = hlbc_pkg::HLBC_TX_SEND;
				end else if (s_q.left == 7'h01) begin
					s_d.st = hlbc_pkg::HLBC_TX_DONE;
				end else begin
					s_d.left = s_q.left - 7'h01;
				end
			end
		end
		hlbc_pkg::HLBC_TX_DONE: begin
			s_d.eot = 1'b1;
			s_d.st = hlbc_pkg::HLBC_TX_IDLE;
		end
		default: s_d.st = hlbc_pkg::HLBC_TX_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '{hlbc_pkg::HLBC_TX_IDLE, hlbc_pkg::CNT_RESET, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.busy = (s_q.st != hlbc_pkg::HLBC_TX_IDLE);
	assign link.eot  = s_q.eot;
endmodule

// >>> verification/hlbc_link_buffer_count_ctrl_monitor.sv
// Purpose: port-level property checks of the buffer/count block
// Assumes: one clock, synchronous active-low reset
// Notes:   irq depends on hidden status, so the bench checks it
`timescale 1ns/10ps
module hlbc_link_buffer_count_ctrl_monitor (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        tx_msg_done,
	input logic        tx_start,
	input logic        tx_buffer_out,
	input logic [6:0]  tx_length_out,
	input logic        message_oriented_mode,
	input logic        tx_busy
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Count and mode as the sequencer took them at start; a later write
	// of the count register does not change a run already under way
	logic [6:0] run_cnt_q;
	logic       run_bit_q;
	always_ff @(posedge aclk) begin
		if (tx_start) begin
			run_cnt_q <= tx_length_out;
			run_bit_q <= !message_oriented_mode;
		end
	end
	sequence launch_s;
		!tx_busy ##1 tx_busy;
	endsequence
	sequence msg_last_s;
		message_oriented_mode && tx_busy && tx_msg_done;
	endsequence
	AST_START_RUN: assert property (tx_start |-> launch_s)
		else $error("start without run");
	AST_BUF_HOLD: assert property (
		tx_busy && $past(tx_busy) |-> $stable(tx_buffer_out))
		else $error("buffer changed in use");
	AST_MSG_END: assert property (msg_last_s |-> ##[1:3] !tx_busy)
		else $error("message send did not end");
	AST_ZERO_FOREVER: assert property (
		tx_busy && run_bit_q && run_cnt_q == 7'h00
		|=> tx_busy) else $error("endless repeat stopped");
	AST_RESET_CLEAR: assert property (disable iff (1'b0)
		!aresetn |=> tx_length_out == 7'h00 && !tx_buffer_out && !tx_busy)
		else $error("reset values wrong");
	AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("response repeated");
	AST_AR_BLOCK: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("taken read not answered");
	AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read data repeated");
	AST_ERR_ZERO: assert property (s_axi_rvalid
		&& s_axi_rresp == hlbc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
		else $error("error read data not zero");
endmodule
bind hlbc_link_buffer_count_ctrl hlbc_link_buffer_count_ctrl_monitor u_mon (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .tx_msg_done, .tx_start,
	.tx_buffer_out, .tx_length_out, .message_oriented_mode, .tx_busy);

// >>> verification/hlbc_link_partner.sv
// Purpose: far-side framer and remote link stand-in
// Assumes: one completion per message or repetition while tx_busy is high
// Notes:   gap sets how slowly the far side answers
`timescale 1ns/10ps
module hlbc_link_partner (
	input  logic       aclk,
	input  logic       aresetn,
	input  logic       tx_busy,
	input  logic [3:0] gap,
	input  logic       rx_req,
	input  logic [6:0] rx_size,
	output logic       tx_msg_done,
	output logic       rx_msg_done,
	output logic [6:0] rx_msg_size
);
	logic [3:0] wait_q;
	always_ff @(posedge aclk) begin
		tx_msg_done <= 1'b0;
		rx_msg_done <= rx_req;
		if (!aresetn || !tx_busy || tx_msg_done) begin
			wait_q <= gap;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end else begin
			tx_msg_done <= 1'b1;
		end
	end
	// Size means nothing off the strobe, so show its inverse there
	assign rx_msg_size = rx_msg_done ? rx_size : ~rx_size;
endmodule

// >>> verification/hlbc_link_buffer_count_ctrl_tb_top.sv
// Purpose: register-level tests of the buffer/count block
// Assumes: AXI4-Lite master tasks, partner supplies link events
// Notes:   waits follow handshakes and are bounded
`timescale 1ns/10ps
`define CHK(a, b, m) begin \
	checks_done++; \
	if ((a) !== (b)) begin \
		n_errors++; \
		$display("FAIL %0t %s", $time, m); \
	end \
end
module hlbc_link_buffer_count_ctrl_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0;
	logic        bre = 1'b0, arv = 1'b0, rre = 1'b0, rxq = 1'b0;
	logic        awr, wr, bv, arr, rv, irq, tmd, rmd, tst, tbuf, mode, busy;
	logic [7:0]  aw = 8'h00, ar = 8'h00;
	logic [31:0] wd = 32'h00000000, rd, got;
	logic [1:0]  br, rr, resp;
	logic [6:0]  rsz = 7'h00, rms, tlen;
	logic [3:0]  gap = 4'h6;
	int          n_errors = 0, checks_done = 0, n_done = 0, n = 0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (tmd) n_done <= n_done + 1;
	hlbc_link_buffer_count_ctrl DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .tx_msg_done(tmd),
		.rx_msg_done(rmd), .rx_msg_size(rms), .tx_start(tst),
		.tx_buffer_out(tbuf), .tx_length_out(tlen),
		.message_oriented_mode(mode), .tx_busy(busy), .irq(irq));
	hlbc_link_partner u_far (.aclk(aclk), .aresetn(aresetn), .tx_busy(busy),
		.gap(gap), .rx_req(rxq), .rx_size(rsz), .tx_msg_done(tmd),
		.rx_msg_done(rmd), .rx_msg_size(rms));
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic tick(input int lim);
		@(posedge aclk);
		n++;
		if (n > lim) begin
			n_errors++;
			$display("FAIL %0t wait limit", $time);
			wrap_up();
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge aclk);
		aw <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do begin
			tick(50);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		bre <= 1'b0;
		resp = br;
	endtask
	task automatic rreg(input logic [7:0] a);
		n = 0;
		@(posedge aclk);
		ar <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			tick(50);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rre <= 1'b0;
		got = rd;
		resp = rr;
	endtask
	task automatic wait_busy(input logic v);
		n = 0;
		while (busy !== v) tick(200);
	endtask
	task automatic rx_msg(input logic [6:0] s);
		@(posedge aclk);
		rxq <= 1'b1;
		rsz <= s;
		@(posedge aclk);
		rxq <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rreg(8'h00);
		`CHK(got, 32'h00000000, "tx reset")
		rreg(8'h04);
		`CHK(got, 32'h00000000, "rx reset")
		rreg(8'h14);
		`CHK(resp, hlbc_pkg::RESP_SLVERR, "unmapped read")
		wreg(8'h14, 32'h00000001);
		`CHK(resp, hlbc_pkg::RESP_SLVERR, "unmapped write")
		$display("Test reset and map done");
		wreg(8'h10, 32'h00000003);
		wreg(8'h00, 32'h00000083);
		`CHK(tst, 1'b1, "start pulse")
		wait_busy(1'b1);
		`CHK({tbuf, tlen}, 8'h83, "buffer one sent")
		rreg(8'h00);
		`CHK(got[7], 1'b0, "other buffer free")
		wait_busy(1'b0);
		`CHK(n_done, 3, "repeat count")
		rreg(8'h00);
		`CHK(got[7:0], 8'h83, "idle select read back")
		rreg(8'h0C);
		`CHK({got[1:0], irq}, 3'b011, "tx end flagged")
		wreg(8'h10, 32'h00000000);
		`CHK(irq, 1'b0, "masked")
		wreg(8'h0C, 32'h00000001);
		wreg(8'h10, 32'h00000003);
		`CHK(irq, 1'b0, "cleared")
		$display("Test bit-oriented send done");
		gap <= 4'h4;
		wreg(8'h08, 32'h00000001);
		wreg(8'h00, 32'h00000014);
		wait_busy(1'b1);
		`CHK({mode, tbuf, tlen}, 9'h114, "message send")
		wait_busy(1'b0);
		`CHK(n_done, 4, "one message")
		wreg(8'h0C, 32'h00000001);
		rx_msg(7'h2A);
		rreg(8'h04);
		`CHK(got[7:0], 8'hAA, "rx in buffer one")
		rx_msg(7'h05);
		rreg(8'h04);
		`CHK(got[7:0], 8'h05, "rx in buffer zero")
		$display("Test message mode done");
		wreg(8'h08, 32'h00000000);
		wreg(8'h04, 32'h00000002);
		rx_msg(7'h11);
		rreg(8'h0C);
		`CHK(got[1], 1'b0, "rx end too early")
		rx_msg(7'h11);
		rreg(8'h0C);
		`CHK({got[1], irq}, 2'b11, "rx end flagged")
		wreg(8'h0C, 32'h00000002);
		wreg(8'h04, 32'h00000000);
		for (int i = 0; i < 3; i++) rx_msg(7'h11);
		rreg(8'h0C);
		`CHK(got[1], 1'b0, "rx zero count ended")
		$display("Test rx repeat done");
		wreg(8'h00, 32'h00000000);
		wait_busy(1'b1);
		repeat (60) @(posedge aclk);
		`CHK(busy, 1'b1, "endless repeat stopped")
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK({busy, tbuf, tlen}, 9'h000, "second reset")
		$display("Test endless repeat and reset done");
		wrap_up();
	end
endmodule
